// >>> hdl/usc_setup_capture.sv
// Setup-packet capture, event flags and interrupt outputs
//
// Summary of operation
// - Request code (second setup byte) is read-only in bits 15:8.
// - First setup byte in bits 7:0; bit 7 direction, bits 6:5 type.
// - Bits 4:0 hold the recipient code as received.
// - Value register holds byte three low and byte four high.
// - Index register holds byte five low and byte six high.
// - Length register holds byte seven low and byte eight high.
// - A mask bit of 0 passes its flag to its output, 1 blocks it.
// - A good endpoint-zero transfer sets the endpoint-zero done flag.
// - Frame-start flag sets on a token, or per frame in own-frame mode.
// - Writing 1 to the NAK flag clears every per-endpoint NAK bit except one that ep_nak sets in that cycle.
`timescale 1ns/100ps
`default_nettype none
module usc_setup_capture
  import usc_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
)(
  input  wire logic                 core_clk,
  input  wire logic                 rst,
  input  wire logic [7:0]           reg_addr,
  input  wire logic [31:0]          reg_wdata,
  input  wire logic                 reg_wr,
  input  wire logic                 reg_rd,
  output logic      [31:0]          reg_rdata,
  input  wire logic                 setup_start,
  input  wire logic                 setup_byte_valid,
  input  wire logic [7:0]           setup_byte,
  input  wire logic                 setup_end,
  input  wire logic                 setup_error,
  input  wire logic                 sof_token,
  input  wire logic                 ep0_done,
  input  wire logic                 ep_done,
  input  wire logic                 zerolen_rx,
  input  wire logic                 status_done,
  input  wire logic                 status_nak,
  input  wire logic [NUM_EP-1:0]    ep_nak,
  output logic      [NUM_FLAGS-1:0] int_lines,
  output logic                      irq
);

  // ----------------------------------------------------------------------
  // Capture of the eight setup bytes
  // ----------------------------------------------------------------------
  usc_cap_state_t state;
  usc_cap_state_t next_state;
  logic [7:0]  shadow [SETUP_BYTES];
  logic [7:0]  next_shadow [SETUP_BYTES];
  logic [3:0]  cnt;
  logic [3:0]  next_cnt;
  logic [15:0] req_type_code;
  logic [15:0] value_f;
  logic [15:0] index_f;
  logic [15:0] length_f;
  logic [15:0] next_req;
  logic [15:0] next_value;
  logic [15:0] next_index;
  logic [15:0] next_length;
  logic        load;

  always_comb
  begin
    next_state  = state;
    next_cnt    = cnt;
    next_shadow = shadow;
    load        = 1'b0;
    case (state)
      CAP_IDLE:
      begin
        if (setup_start)
        begin
          next_state = CAP_RECV;
          next_cnt   = 4'h0;
        end
      end
      CAP_RECV:
      begin
        if (setup_error)
        begin
          next_state = CAP_DROP;
        end
        else if (setup_end)
        begin
          next_state = CAP_DONE;
          // Short or long packets never disturb the last good request
          load = (cnt == 4'(SETUP_BYTES)) && !setup_byte_valid;
        end
        else if (setup_byte_valid)
        begin
          if (cnt < 4'(SETUP_BYTES))
            next_shadow[cnt[2:0]] = setup_byte;
          // Count saturates so a runaway packet cannot wrap back to eight
          if (cnt != 4'hf)
            next_cnt = cnt + 4'h1;
        end
      end
      CAP_DONE:
      begin
        next_state = CAP_IDLE;
      end
      default:
      begin
        if (setup_end)
        begin
          next_state = CAP_IDLE;
        end
      end
    endcase
    next_req    = req_type_code;
    next_value  = value_f;
    next_index  = index_f;
    next_length = length_f;
    if (load)
    begin
      next_req    = {shadow[1], shadow[0]};
      next_value  = {shadow[3], shadow[2]};
      next_index  = {shadow[5], shadow[4]};
      next_length = {shadow[7], shadow[6]};
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      state         <= CAP_IDLE;
      cnt           <= 4'h0;
      shadow        <= '{default: RST_BYTE};
      req_type_code <= RST_FIELD;
      value_f       <= RST_FIELD;
      index_f       <= RST_FIELD;
      length_f      <= RST_FIELD;
    end
    else
    begin
      state         <= next_state;
      cnt           <= next_cnt;
      shadow        <= next_shadow;
      req_type_code <= next_req;
      value_f       <= next_value;
      index_f       <= next_index;
      length_f      <= next_length;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags, masks, per-endpoint NAK and summary interrupt
  // ----------------------------------------------------------------------
  logic [NUM_FLAGS-1:0] flags;
  logic [NUM_FLAGS-1:0] masks;
  logic [NUM_EP-1:0]    nak_bits;
  logic [1:0]           sys_stat;
  logic [1:0]           sys_mask;
  logic                 own_sof;
  logic                 frame_tick;
  logic [NUM_FLAGS-1:0] ev;
  logic [NUM_FLAGS-1:0] next_flags;
  logic [NUM_FLAGS-1:0] next_masks;
  logic [NUM_EP-1:0]    next_nak;
  logic [1:0]           next_sys_stat;
  logic [1:0]           next_sys_mask;
  logic                 next_own_sof;
  logic [NUM_FLAGS-1:0] next_int_lines;
  logic                 next_irq;
  logic                 wr_int;

  usc_frame_timer #(
    .FRAME_LEN (FRAME_LEN)
  ) u_frame (
    .core_clk (core_clk),
    .rst      (rst),
    .enable   (own_sof),
    .tick     (frame_tick)
  );

  always_comb
  begin
    ev               = '0;
    ev[FLG_NAK]      = |ep_nak;
    ev[FLG_EP]       = ep_done;
    ev[FLG_EP0]      = ep0_done;
    ev[FLG_SOF]      = own_sof ? frame_tick : sof_token;
    ev[FLG_RX0]      = zerolen_rx;
    ev[FLG_STATUS]   = status_done;
    ev[FLG_STATNAK]  = status_nak;
    ev[FLG_SETUP]    = load;
    wr_int           = reg_wr && (reg_addr == OFF_INT);
    next_masks       = masks;
    next_own_sof     = own_sof;
    next_sys_mask    = sys_mask;
    next_flags       = flags;
    next_nak         = nak_bits;
    next_sys_stat    = sys_stat;
    if (wr_int)
    begin
      next_masks = reg_wdata[MASK_LSB +: NUM_FLAGS];
      next_flags = flags & ~reg_wdata[NUM_FLAGS-1:0];
      if (reg_wdata[FLG_NAK])
        next_nak = '0;
    end
    if (reg_wr && (reg_addr == OFF_SYSSTAT))
      next_sys_stat = sys_stat & ~reg_wdata[1:0];
    if (reg_wr && (reg_addr == OFF_SYSMASK))
      next_sys_mask = reg_wdata[1:0];
    if (reg_wr && (reg_addr == OFF_CTRL))
      next_own_sof = reg_wdata[CTRL_OWN_SOF];
    // Set beats clear so no event is lost
    next_flags = next_flags | ev;
    next_nak   = next_nak | ep_nak;
    next_sys_stat = next_sys_stat | {ev[FLG_SOF], load};
    next_int_lines = next_flags & ~next_masks;
    next_irq       = |(next_sys_stat & ~next_sys_mask);
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      flags     <= '0;
      masks     <= '0;
      nak_bits  <= '0;
      sys_stat  <= 2'h0;
      sys_mask  <= 2'h0;
      own_sof   <= 1'b0;
      int_lines <= '0;
      irq       <= 1'b0;
    end
    else
    begin
      flags     <= next_flags;
      masks     <= next_masks;
      nak_bits  <= next_nak;
      sys_stat  <= next_sys_stat;
      sys_mask  <= next_sys_mask;
      own_sof   <= next_own_sof;
      int_lines <= next_int_lines;
      irq       <= next_irq;
    end
  end

  // ----------------------------------------------------------------------
  // Register read port
  // ----------------------------------------------------------------------
  logic [31:0] next_rdata;

  always_comb
  begin
    next_rdata = RD_ZERO;
    if (!reg_rd)
      next_rdata = RD_ZERO;
    else if (reg_addr == OFF_REQ)
      next_rdata = {16'h0000, req_type_code};
    else if (reg_addr == OFF_VALUE)
      next_rdata = {16'h0000, value_f};
    else if (reg_addr == OFF_INDEX)
      next_rdata = {16'h0000, index_f};
    else if (reg_addr == OFF_LENGTH)
      next_rdata = {16'h0000, length_f};
    else if (reg_addr == OFF_INT)
      next_rdata = {16'h0000, masks, flags};
    else if (reg_addr == OFF_NAK)
      next_rdata = {24'h00_0000, nak_bits};
    else if (reg_addr == OFF_SYSSTAT)
      next_rdata = {30'h0000_0000, sys_stat};
    else if (reg_addr == OFF_SYSMASK)
      next_rdata = {30'h0000_0000, sys_mask};
    else if (reg_addr == OFF_CTRL)
      next_rdata = {31'h0000_0000, own_sof};
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      reg_rdata <= RD_ZERO;
    end
    else
    begin
      reg_rdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  AST_LOAD_REQ: assert property (@(posedge core_clk) disable iff (rst)
    load |=> req_type_code[15:8] == $past(shadow[1]) &&
             req_type_code[7:0] == $past(shadow[0]))
    else $error("request register not loaded");
  AST_HOLD: assert property (@(posedge core_clk) disable iff (rst)
    !load |=> $stable(req_type_code) && $stable(value_f) &&
              $stable(index_f) && $stable(length_f))
    else $error("capture changed without a good packet");
  AST_VALUE: assert property (@(posedge core_clk) disable iff (rst)
    load |=> value_f[7:0] == $past(shadow[2]))
    else $error("value low byte wrong");
  AST_INDEX: assert property (@(posedge core_clk) disable iff (rst)
    load |=> index_f[15:8] == $past(shadow[5]))
    else $error("index high byte wrong");
  AST_LENGTH: assert property (@(posedge core_clk) disable iff (rst)
    load |=> length_f[15:8] == $past(shadow[7]) &&
             length_f[7:0] == $past(shadow[6]))
    else $error("length wrong");
  AST_TYPE: assert property (@(posedge core_clk) disable iff (rst)
    load |=> req_type_code[6:5] == $past(shadow[0][6:5]))
    else $error("type field wrong");
  AST_RECIP: assert property (@(posedge core_clk) disable iff (rst)
    load |=> req_type_code[4:0] == $past(shadow[0][4:0]))
    else $error("recipient field wrong");
  AST_MASK: assert property (@(posedge core_clk) disable iff (rst)
    int_lines == (flags & ~masks))
    else $error("interrupt line not gated by mask");
  AST_EP0: assert property (@(posedge core_clk) disable iff (rst)
    ep0_done |=> flags[FLG_EP0])
    else $error("endpoint-zero flag not set");
  AST_SOF: assert property (@(posedge core_clk) disable iff (rst)
    (sof_token && !own_sof) |=> flags[FLG_SOF])
    else $error("frame-start flag not set");
  AST_NAK: assert property (@(posedge core_clk) disable iff (rst)
    (wr_int && reg_wdata[FLG_NAK] && ep_nak == '0) |=> nak_bits == '0)
    else $error("nak register not cleared");

  COV_LOAD: cover property (@(posedge core_clk) disable iff (rst) load);
  COV_DROP: cover property (@(posedge core_clk) disable iff (rst)
    state == CAP_DROP);
  COV_IRQ: cover property (@(posedge core_clk) disable iff (rst) irq);
  COV_OWN: cover property (@(posedge core_clk) disable iff (rst)
    own_sof && frame_tick);

endmodule : usc_setup_capture
`default_nettype wire

// >>> hdl/usc_pkg.sv
// Package of constants for the setup-packet capture block
package usc_pkg;

  // ----------------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFF_REQ      = 8'h00;
  localparam logic [7:0] OFF_VALUE    = 8'h04;
  localparam logic [7:0] OFF_INDEX    = 8'h08;
  localparam logic [7:0] OFF_LENGTH   = 8'h0c;
  localparam logic [7:0] OFF_INT      = 8'h10;
  localparam logic [7:0] OFF_NAK      = 8'h14;
  localparam logic [7:0] OFF_SYSSTAT  = 8'h18;
  localparam logic [7:0] OFF_SYSMASK  = 8'h1c;
  localparam logic [7:0] OFF_CTRL     = 8'h20;

  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int BIT_DIR       = 7;
  localparam int TYPE_LSB      = 5;
  localparam int RECIP_LSB     = 0;
  localparam int MASK_LSB      = 8;
  localparam int FLG_NAK       = 7;
  localparam int FLG_EP        = 6;
  localparam int FLG_EP0       = 5;
  localparam int FLG_SOF       = 4;
  localparam int FLG_RX0       = 3;
  localparam int FLG_STATUS    = 2;
  localparam int FLG_STATNAK   = 1;
  localparam int FLG_SETUP     = 0;
  localparam int CTRL_OWN_SOF  = 0;

  localparam int NUM_FLAGS     = 8;
  localparam int NUM_EP        = 8;
  localparam int SETUP_BYTES   = 8;

  // ----------------------------------------------------------------------
  // Reset values and timing
  // ----------------------------------------------------------------------
  localparam logic [15:0] RST_FIELD  = 16'h0000;
  localparam logic [7:0]  RST_BYTE   = 8'h00;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
  localparam int CLK_PERIOD_NS       = 10;
  localparam int FRAME_TIME_NS       = 1000000;
  localparam int FRAME_CYCLES        = FRAME_TIME_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // Capture states
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    CAP_IDLE = 2'b00,
    CAP_RECV = 2'b01,
    CAP_DONE = 2'b10,
    CAP_DROP = 2'b11
  } usc_cap_state_t;

endpackage : usc_pkg

// >>> hdl/usc_frame_timer.sv
// Frame-time counter for self-generated start-of-frame events
`timescale 1ns/100ps
`default_nettype none
module usc_frame_timer
  import usc_pkg::*;
#(
  parameter int FRAME_LEN = FRAME_CYCLES
)(
  input  wire logic core_clk,
  input  wire logic rst,
  input  wire logic enable,
  output logic      tick
);

  // ----------------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------------
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        next_tick;

  always_comb
  begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (!enable)
    begin
      next_cnt = 32'h0000_0000;
    end
    else if (cnt == 32'(FRAME_LEN - 1))
    begin
      next_cnt  = 32'h0000_0000;
      next_tick = 1'b1;
    end
    else
    begin
      next_cnt = cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      cnt  <= 32'h0000_0000;
      tick <= 1'b0;
    end
    else
    begin
      cnt  <= next_cnt;
      tick <= next_tick;
    end
  end

endmodule : usc_frame_timer
`default_nettype wire

// >>> verification/usc_host_model.sv
// Host-side model that sends setup data packets
`timescale 1ns/100ps
`default_nettype none
module usc_host_model
(
  input  wire logic       core_clk,
  output logic            setup_start,
  output logic            setup_byte_valid,
  output logic [7:0]      setup_byte,
  output logic            setup_end,
  output logic            setup_error
);
  initial
  begin
    setup_start      = 1'b0;
    setup_byte_valid = 1'b0;
    setup_byte       = 8'h5a;
    setup_end        = 1'b0;
    setup_error      = 1'b0;
  end

  // ----------------------------------------------------------------------
  // Packet sender
  // ----------------------------------------------------------------------
  // Byte 1 in the low bits; err pulses beside the fourth byte
  task automatic send(input logic [63:0] pkt, input int nbytes,
                      input logic err);
    @(posedge core_clk);
    setup_start <= 1'b1;
    for (int i = 0; i < nbytes; i++)
    begin
      @(posedge core_clk);
      setup_start      <= 1'b0;
      setup_byte_valid <= 1'b1;
      setup_byte       <= pkt[i*8 +: 8];
      setup_error      <= err && (i == 3);
    end
    @(posedge core_clk);
    setup_start      <= 1'b0;
    setup_byte_valid <= 1'b0;
    setup_error      <= 1'b0;
    // Idle byte lane shows a changing value, never the last byte
    setup_byte       <= ~setup_byte;
    setup_end        <= 1'b1;
    @(posedge core_clk);
    setup_end <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : send
endmodule : usc_host_model
`default_nettype wire

// >>> verification/tb_top.sv
// Self-checking bench for the setup-packet capture block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import usc_pkg::*;
  localparam int FLEN = 16;
  typedef struct packed {logic [63:0] pkt; logic [15:0] req;} usc_row_t;

  logic        core_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic        setup_start, setup_byte_valid, setup_end, setup_error;
  logic [7:0]  setup_byte;
  logic [7:0]  ev = 8'h00;
  logic [7:0]  ep_nak = 8'h00;
  logic [7:0]  int_lines;
  logic        irq;
  logic [31:0] rd;
  int          bad_count = 0;
  int          cmp_count = 0;
  usc_row_t    rows [5] = '{
    '{64'h0012_0000_0100_0680, 16'h0680},
    '{64'h0008_0001_0200_0921, 16'h0921},
    '{64'hffff_8081_a55a_5ac2, 16'h5ac2},
    '{64'h0000_ffff_0000_ff63, 16'hff63},
    '{64'h1234_5678_9abc_00ff, 16'h00ff}};

  initial
  begin
    forever #5 core_clk = ~core_clk;
  end

  usc_host_model u_usc_host_model (.core_clk(core_clk),
    .setup_start(setup_start), .setup_byte_valid(setup_byte_valid),
    .setup_byte(setup_byte), .setup_end(setup_end),
    .setup_error(setup_error));

  usc_setup_capture #(.FRAME_LEN(FLEN)) u_usc_setup_capture (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .setup_start(setup_start),
    .setup_byte_valid(setup_byte_valid), .setup_byte(setup_byte),
    .setup_end(setup_end), .setup_error(setup_error),
    .sof_token(ev[FLG_SOF]), .ep0_done(ev[FLG_EP0]),
    .ep_done(ev[FLG_EP]), .zerolen_rx(ev[FLG_RX0]),
    .status_done(ev[FLG_STATUS]), .status_nak(ev[FLG_STATNAK]),
    .ep_nak(ep_nak), .int_lines(int_lines), .irq(irq));

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : reg_write

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a);
    @(posedge core_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 rd = reg_rdata;
  endtask : reg_read

  task automatic read_check(input string n, input logic [7:0] a,
                            input logic [31:0] e);
    reg_read(a);
    check(n, rd, e);
  endtask : read_check

  task automatic capture_check(input usc_row_t r);
    read_check("req", OFF_REQ, {16'h0, r.req});
    read_check("value", OFF_VALUE, {16'h0, r.pkt[31:16]});
    read_check("index", OFF_INDEX, {16'h0, r.pkt[47:32]});
    read_check("length", OFF_LENGTH, {16'h0, r.pkt[63:48]});
  endtask : capture_check

  task automatic complete_run();
    $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : complete_run

  // Whole run is a few hundred cycles
  initial
  begin
    #300us;
    bad_count++;
    complete_run();
  end

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    capture_check('{64'h0, 16'h0});
    read_check("int reset", OFF_INT, 32'h0);
    read_check("unmapped", 8'h40, 32'h0);
    $display("reset test done");
    foreach (rows[i])
    begin
      u_usc_host_model.send(rows[i].pkt, SETUP_BYTES, 1'b0);
      capture_check(rows[i]);
      read_check("setup flag", OFF_INT, 32'h0000_0001);
      check("setup line", int_lines, 8'h01);
      reg_write(OFF_INT, 32'h0000_0001);
    end
    $display("table test done");
    // Read-only fields ignore writes
    reg_write(OFF_REQ, 32'hffff_ffff);
    reg_write(OFF_VALUE, 32'hffff_ffff);
    // Bad and short packets must leave the last good capture standing
    u_usc_host_model.send(64'h1111_2222_3333_4444, SETUP_BYTES, 1'b1);
    u_usc_host_model.send(64'h5555_6666_7777_8888, 7, 1'b0);
    capture_check(rows[4]);
    read_check("no flag", OFF_INT, 32'h0);
    check("irq set", irq, 1'b1);
    reg_write(OFF_SYSMASK, 32'h0000_0003);
    repeat (2) @(posedge core_clk);
    check("irq masked", irq, 1'b0);
    read_check("sys stat", OFF_SYSSTAT, 32'h1);
    read_check("sys mask", OFF_SYSMASK, 32'h3);
    reg_write(OFF_SYSMASK, 32'h0);
    reg_write(OFF_SYSSTAT, 32'hffff_ffff);
    repeat (2) @(posedge core_clk);
    check("irq cleared", irq, 1'b0);
    $display("refusal test done");
    // Each event sets its flag; a mask of 1 blocks only the line
    for (int b = FLG_STATNAK; b <= FLG_EP; b++)
    begin
      @(posedge core_clk);
      ev[b] <= 1'b1;
      @(posedge core_clk);
      ev <= 8'h00;
      repeat (2) @(posedge core_clk);
      read_check("event flag", OFF_INT, 32'h1 << b);
      check("line open", int_lines, 8'h1 << b);
      reg_write(OFF_INT, 32'h100 << b);
      repeat (2) @(posedge core_clk);
      check("line masked", int_lines, 8'h0);
      reg_write(OFF_INT, 32'h1 << b);
      read_check("flag cleared", OFF_INT, 32'h0);
    end
    $display("event test done");
    // Own frame mode sets the frame flag after one frame time
    reg_write(OFF_CTRL, 32'h1);
    // Token is ignored and no flag comes before one frame time
    @(posedge core_clk);
    ev[FLG_SOF] <= 1'b1;
    @(posedge core_clk);
    ev <= 8'h00;
    repeat (FLEN - 6) @(posedge core_clk);
    read_check("early frame", OFF_INT, 32'h0);
    repeat (6) @(posedge core_clk);
    reg_write(OFF_CTRL, 32'h0);
    reg_read(OFF_INT);
    check("own frame", rd[FLG_SOF], 1'b1);
    reg_write(OFF_INT, 32'h0000_00ff);
    // Per-endpoint NAK bits stick until the NAK flag is written with 1
    @(posedge core_clk);
    ep_nak <= 8'h24;
    @(posedge core_clk);
    ep_nak <= 8'h00;
    repeat (2) @(posedge core_clk);
    read_check("nak bits", OFF_NAK, 32'h24);
    read_check("nak flag", OFF_INT, 32'h80);
    check("nak line", int_lines, 8'h80);
    reg_write(OFF_INT, 32'h80);
    read_check("nak cleared", OFF_NAK, 32'h0);
    read_check("nak flag off", OFF_INT, 32'h0);
    $display("nak test done");
    // Second reset in mid-run
    @(posedge core_clk);
    rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    capture_check('{64'h0, 16'h0});
    check("irq reset", irq, 1'b0);
    check("lines reset", int_lines, 8'h00);
    $display("second reset test done");
    complete_run();
  end
endmodule : tb_top
`default_nettype wire
